// File: core/sci_pkg.sv
package sci_pkg;
  // APB register byte offsets.
  localparam logic [7:0] SCI_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCI_STAT_OFS = 8'h04;
  localparam logic [7:0] SCI_IRQ_OFS = 8'h08;
  localparam logic [7:0] SCI_MASK_OFS = 8'h0c;
  // Control register fields.
  localparam int SCI_CTRL_SW_EN = 0;
  localparam int SCI_CTRL_SW_CMD = 1;
  localparam logic [31:0] SCI_CTRL_RST = 32'h0000_0000;
  // Interrupt status fields, one per event.
  localparam int SCI_EV_CARD_PRESENCE = 0;
  localparam int SCI_EV_REMOVE = 1;
  localparam int SCI_EV_OVC = 2;
  localparam int SCI_EV_VCCF = 3;
  localparam int SCI_EV_VDDF = 4;
  localparam int SCI_EV_DEACT = 5;
  localparam int SCI_EV_W = 6;
  localparam logic [5:0] SCI_MASK_RST = 6'h00;
  // Divide select codes as {high, low}.
  localparam logic [1:0] SCI_DIV6 = 2'h0;
  localparam logic [1:0] SCI_DIV4 = 2'h1;
  localparam logic [1:0] SCI_DIV1 = 2'h2;
  localparam logic [1:0] SCI_DIV2 = 2'h3;
  // Timing: activation/deactivation step time and card clock limit.
  localparam int SCI_CLK_MHZ = 40;
  localparam int SCI_STEP_NS = 1000;
  localparam int SCI_STEP_CYC = (SCI_STEP_NS * SCI_CLK_MHZ + 999) / 1000;
  localparam int SCI_CARD_CLK_MAX_MHZ = 20;
  // Sequencer states.
  typedef enum logic [5:0]
  {
    SCI_IDLE = 6'h01,
    SCI_ACT = 6'h02,
    SCI_ON = 6'h04,
    SCI_D_CLK = 6'h08,
    SCI_D_IO = 6'h10,
    SCI_D_VCC = 6'h20
  } sci_state_e;
endpackage : sci_pkg

// File: core/sci_clkdiv.sv
`timescale 1ns/1ps
// Card clock divider on the system clock; the oscillator is sampled as a pin.
module sci_clkdiv
  import sci_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control.
  input wire logic i_osc,
  input wire logic [1:0] i_div_sel,
  input wire logic i_run,
  // Output.
  output logic o_card_clk
);
  logic [2:0] osc_sync_reg;
  logic osc_reg;
  logic osc_rise;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] half;
  logic clk_reg;
  logic clk_next;
  logic toggle;

  // Three flops; the oscillator counts once stages two and three agree.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      osc_sync_reg <= 3'h0;
      osc_reg <= 1'b0;
    end
    else
    begin
      osc_sync_reg <= {osc_sync_reg[1:0], i_osc};
      if (osc_sync_reg[1] == osc_sync_reg[2])
        osc_reg <= osc_sync_reg[2];
    end
  end
  assign osc_rise = (osc_sync_reg[1] == osc_sync_reg[2]) && osc_sync_reg[2] && !osc_reg;

  // Edges counted per half period: divide N toggles every N/2 source edges.
  // Divide by one follows the oscillator level itself.
  assign half = (i_div_sel == SCI_DIV6) ? 3'h3 :
                (i_div_sel == SCI_DIV4) ? 3'h2 : 3'h1;
  // A count left above the new end point by a divide change wraps at once, not after 8 edges.
  assign toggle = osc_rise && (cnt_reg >= half - 3'h1);
  assign cnt_next = !i_run ? 3'h0 : toggle ? 3'h0 : osc_rise ? cnt_reg + 3'h1 : cnt_reg;
  assign clk_next = !i_run ? 1'b0 :
                    (i_div_sel == SCI_DIV1) ? osc_reg :
                    toggle ? !clk_reg : clk_reg;

  // Stopped clock parks low; as a flop on the system clock it never beats above half of it.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      cnt_reg <= 3'h0;
      clk_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end
  assign o_card_clk = clk_reg;
endmodule : sci_clkdiv

// File: core/sci_ctrl.sv
`timescale 1ns/1ps
// Smart card interface control: sequencer, faults, data relay, APB status.
module sci_ctrl
  import sci_pkg::*;
#(
  parameter int STEP_CYC = SCI_STEP_CYC
)
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Host control pins.
  input wire logic i_supply_command_n,
  input wire logic i_card_voltage_select,
  input wire logic i_divide_select_high,
  input wire logic i_divide_select_low,
  input wire logic i_card_reset_request,
  input wire logic i_oscillator_input,
  // Card status and fault detectors.
  input wire logic i_card_presence,
  input wire logic i_overcurrent,
  input wire logic i_vcc_fault,
  input wire logic i_vdd_fault,
  // Host data line, open drain.
  input wire logic i_host_data_line,
  output logic o_host_data_line,
  output logic o_host_data_line_oe,
  // Card data line, open drain.
  input wire logic i_card_data,
  output logic o_card_data,
  output logic o_card_data_oe,
  // Card outputs.
  output logic o_card_supply_en,
  output logic o_card_5v,
  output logic o_card_reset,
  output logic o_card_clock,
  // Interrupt pin, open drain.
  output logic o_int_b,
  output logic o_int_b_oe,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  // Pin synchronisers: three stages, a change counts when two and three agree.
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [NPIN-1:0] pin_s3_reg;
  logic [NPIN-1:0] pin_reg;
  assign pin_raw = {i_divide_select_high, i_divide_select_low, i_card_data, i_host_data_line,
                    i_vdd_fault, i_vcc_fault, i_overcurrent,
                    i_card_presence, i_card_reset_request, i_card_voltage_select,
                    i_supply_command_n};

  // Reset values mirror the pull resistors so nothing acts before sampling.
  // Both divide selects reset high like their pull-ups, giving divide by two.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      pin_s1_reg <= 11'h783;
      pin_s2_reg <= 11'h783;
      pin_s3_reg <= 11'h783;
      pin_reg <= 11'h783;
    end
    else
    begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  wire cmd_n = pin_reg[0];
  wire volt5 = pin_reg[1];
  wire rst_req = pin_reg[2];
  wire present = pin_reg[3]; // High means card inserted.
  wire ovc = pin_reg[4];
  wire vccf = pin_reg[5];
  wire vddf = pin_reg[6];
  wire host_in = pin_reg[7];
  wire card_in = pin_reg[8];
  wire div_low = pin_reg[9];
  wire div_high = pin_reg[10];

  // Registers.
  logic [1:0] ctrl_reg;
  logic [5:0] irq_reg;
  logic [5:0] irq_next;
  logic [5:0] mask_reg;
  logic [5:0] ev;
  logic present_d_reg;
  sci_state_e state_reg;
  sci_state_e state_next;
  logic [15:0] tmr_reg;
  logic tmr_done;
  logic fault;
  logic cmd_act;
  logic volt5_reg;
  logic [1:0] owner_reg;
  logic [1:0] owner_next;

  // Software override selects the command source when enabled.
  assign cmd_act = ctrl_reg[SCI_CTRL_SW_EN] ? ctrl_reg[SCI_CTRL_SW_CMD] : !cmd_n;
  assign fault = !present || ovc || vccf || vddf;
  assign tmr_done = (tmr_reg == 16'h0);

  // Sequencer next state; only it controls supply, clock and data.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SCI_IDLE: if (cmd_act && present && !fault) state_next = SCI_ACT;
      SCI_ACT:
      begin
        if (fault || !cmd_act) state_next = SCI_D_CLK;
        else if (tmr_done) state_next = SCI_ON;
      end
      SCI_ON: if (fault || !cmd_act) state_next = SCI_D_CLK;
      SCI_D_CLK: if (tmr_done) state_next = SCI_D_IO;
      SCI_D_IO: if (tmr_done) state_next = SCI_D_VCC;
      SCI_D_VCC: if (tmr_done) state_next = SCI_IDLE;
      default: state_next = SCI_IDLE;
    endcase
  end

  // Step timer restarts on every state change.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      state_reg <= SCI_IDLE;
      tmr_reg <= 16'h0;
    end
    else
    begin
      state_reg <= state_next;
      tmr_reg <= (state_next != state_reg) ? 16'(STEP_CYC - 1) :
                 tmr_done ? 16'h0 : tmr_reg - 16'h1;
    end
  end

  // Voltage choice latched at idle; the register holds it steady while active.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      volt5_reg <= 1'b1;
    else if (state_reg == SCI_IDLE)
      volt5_reg <= volt5;
  end

  // Supply stays on until the last deactivation step.
  assign o_card_supply_en = (state_reg != SCI_IDLE);
  assign o_card_5v = volt5_reg;
  // Reset follows the host request only while fully on; drops first.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      o_card_reset <= 1'b0;
    else
      o_card_reset <= (state_reg == SCI_ON) && !fault && cmd_act && rst_req;
  end

  // Clock runs during activation and on, stops low at the clock step.
  // It keeps running until the reset drop has landed, so reset always falls first.
  sci_clkdiv u_div
  (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_osc(i_oscillator_input),
    .i_div_sel({div_high, div_low}),
    .i_run((state_reg == SCI_ACT) || (state_reg == SCI_ON) ||
           ((state_reg == SCI_D_CLK) && o_card_reset)),
    .o_card_clk(o_card_clock)
  );

  // Data relay: owner 1 = host drives card line, 2 = card drives host line.
  // Owner 3 drives nothing and waits for both lines to read high again; without it the
  // delayed echo of our own drive would look like a fresh start from the other side.
  always_comb
  begin
    owner_next = owner_reg;
    if (state_reg != SCI_ON) owner_next = 2'h0;
    else if (owner_reg == 2'h0 && !host_in) owner_next = 2'h1;
    else if (owner_reg == 2'h0 && !card_in) owner_next = 2'h2;
    else if (owner_reg == 2'h1 && host_in) owner_next = 2'h3;
    else if (owner_reg == 2'h2 && card_in) owner_next = 2'h3;
    else if (owner_reg == 2'h3 && host_in && card_in) owner_next = 2'h0;
  end
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      owner_reg <= 2'h0;
    else
      owner_reg <= owner_next;
  end
  // Card data is held low from the data step until the supply drops.
  assign o_card_data = 1'b0;
  assign o_card_data_oe = (owner_reg == 2'h1) || (state_reg == SCI_D_IO) ||
                          (state_reg == SCI_D_VCC);
  assign o_host_data_line = 1'b0;
  assign o_host_data_line_oe = (owner_reg == 2'h2);

  // Events: presence edge, removal, each fault, deactivation done.
  assign ev = {(state_reg == SCI_D_VCC) && tmr_done, vddf, vccf, ovc,
               !present && present_d_reg, present && !present_d_reg};
  // Set wins over a write-one clear.
  assign irq_next = (irq_reg & ~((i_psel && i_penable && i_pwrite &&
                    i_paddr == SCI_IRQ_OFS) ? i_pwdata[5:0] : 6'h0)) | ev;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      irq_reg <= 6'h0;
      present_d_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
      present_d_reg <= present;
    end
  end
  // Open-drain active-low interrupt; the pad pull-up gives the high.
  assign o_int_b = 1'b0;
  assign o_int_b_oe = |(irq_reg & mask_reg);

  // APB: zero-wait, unmapped addresses answer with an error.
  wire acc = i_psel && i_penable;
  wire hit = (i_paddr == SCI_CTRL_OFS) || (i_paddr == SCI_STAT_OFS) ||
             (i_paddr == SCI_IRQ_OFS) || (i_paddr == SCI_MASK_OFS);
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit;
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      ctrl_reg <= SCI_CTRL_RST[1:0];
      mask_reg <= SCI_MASK_RST;
    end
    else if (acc && i_pwrite)
    begin
      if (i_paddr == SCI_CTRL_OFS) ctrl_reg <= i_pwdata[1:0];
      if (i_paddr == SCI_MASK_OFS) mask_reg <= i_pwdata[5:0];
    end
  end
  // Read data registered in the setup phase so it is stable at the access edge.
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      o_prdata <= 32'h0;
    else if (i_psel && !i_penable)
    begin
      case (i_paddr)
        SCI_CTRL_OFS: o_prdata <= {30'h0, ctrl_reg};
        SCI_STAT_OFS: o_prdata <= {20'h0, owner_reg, state_reg, vddf, vccf, ovc, present};
        SCI_IRQ_OFS: o_prdata <= {26'h0, irq_reg};
        SCI_MASK_OFS: o_prdata <= {26'h0, mask_reg};
        default: o_prdata <= 32'h0;
      endcase
    end
  end

  // Assertions; helper nets name the start condition and a mask write.
  wire act_ok = (state_reg == SCI_IDLE) && cmd_act && present && !fault;
  wire mask_wr = acc && i_pwrite && (i_paddr == SCI_MASK_OFS);
  supply_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $rose(o_card_supply_en) |-> $past(act_ok))
    else $error("supply on without command");
  fault_deact_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_ON && fault) |=> (state_reg == SCI_D_CLK)) else $error("no deact");
  act_start_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_IDLE && cmd_act && present && !fault) |=> (state_reg == SCI_ACT))
    else $error("no activation");
  rst_first_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_D_IO) |-> !o_card_reset) else $error("reset high in deact");
  clk_stop_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_D_IO) |-> !o_card_clock) else $error("clock running");
  int_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    ((|(ev & mask_reg)) && !mask_wr) |=> o_int_b_oe) else $error("interrupt lost");
  relay_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !(o_card_data_oe && o_host_data_line_oe)) else $error("both lines driven");
  rst_pass_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_ON && !fault && cmd_act && rst_req) |=> o_card_reset)
    else $error("reset not passed");
  // Deactivation steps: the move out of the on state, then reset held low.
  sequence leave_on_s;
    (state_reg == SCI_ON) ##1 (state_reg == SCI_D_CLK);
  endsequence
  sequence reset_low_s;
    !o_card_reset [*2];
  endsequence
  deact_order_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    leave_on_s |=> reset_low_s) else $error("reset not dropped first");
  clk_park_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == SCI_D_CLK && !o_card_reset) |=> !o_card_clock)
    else $error("clock not parked");
  volt_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg != SCI_IDLE) |=> $stable(o_card_5v))
    else $error("voltage changed in session");
endmodule : sci_ctrl

// File: verification/sci_card_model.sv
`timescale 1ns/1ps
// Card side of the data line: the card may pull the shared open-drain line low.
module sci_card_model
(
  // Parties that may pull the line low.
  input wire logic i_dut_oe,
  input wire logic i_card_pull,
  // Resolved line level.
  output logic o_level
);
  // The line has a pull-up, so it reads high whenever nobody drives it low.
  assign o_level = !(i_dut_oe | i_card_pull);
endmodule : sci_card_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sci_pkg::*;
  localparam int STEP = 4;
  logic clk = 0, rst_b = 0, cmd_n = 1, vsel = 1, dh = 1, dl = 1, rreq = 0, osc = 0;
  logic card_presence = 0, hpull = 0, cpull = 0, psel = 0, pen = 0, pwr = 0, err, ck_q = 0;
  logic [3:0] flt = 4'h0;
  logic [7:0] paddr = 8'h00, cnt = 8'h00, per = 8'h00, oc = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic h_oe, c_oe, sup, v5, crst, cclk, int_oe, pready, pslverr, h_o, c_o, int_o, cline;
  logic hline;
  logic [1:0] codes [4] = '{SCI_DIV6, SCI_DIV4, SCI_DIV1, SCI_DIV2};
  int divs [4] = '{6, 4, 1, 2};
  int errors = 0, checks = 0, t, k, i, t_rst, t_do;
  // The host line has its own pull-up; the bench stands in for the host here.
  assign hline = !(hpull | h_oe);
  sci_card_model card_u (.i_dut_oe(c_oe), .i_card_pull(cpull), .o_level(cline));
  sci_ctrl #(.STEP_CYC(STEP)) dut_u (
    .i_clock(clk), .i_rst_b(rst_b), .i_supply_command_n(cmd_n),
    .i_card_voltage_select(vsel), .i_divide_select_high(dh), .i_divide_select_low(dl),
    .i_card_reset_request(rreq), .i_oscillator_input(osc), .i_card_presence(card_presence & !flt[3]),
    .i_overcurrent(flt[0]), .i_vcc_fault(flt[1]), .i_vdd_fault(flt[2]),
    .i_host_data_line(hline), .o_host_data_line(h_o), .o_host_data_line_oe(h_oe),
    .i_card_data(cline), .o_card_data(c_o), .o_card_data_oe(c_oe),
    .o_card_supply_en(sup), .o_card_5v(v5), .o_card_reset(crst), .o_card_clock(cclk),
    .o_int_b(int_o), .o_int_b_oe(int_oe), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  // System clock at 40 MHz.
  initial
  begin
    forever #12.5 clk = !clk;
  end
  // Oscillator of six cycles, well under the card clock limit even undivided.
  always @(posedge clk)
  begin
    oc <= (oc == 8'h02) ? 8'h00 : oc + 8'h01;
    if (oc == 8'h02) osc <= !osc;
  end
  // Measures the card clock period in system cycles between rising edges.
  always @(posedge clk)
  begin
    ck_q <= cclk;
    if (cclk && !ck_q)
    begin
      per <= cnt;
      cnt <= 8'h01;
    end
    else cnt <= cnt + 8'h01;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One APB transfer; data and response are taken at the edge where pready is seen.
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task finish_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Cuts a hang short well beyond the expected thousand or so cycles.
  initial
  begin
    #750000;
    errors++;
    finish_test();
  end
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    cyc(4);
    check(v5, 1'b1);
    check(int_oe, 1'b0);
    check({h_o, c_o, int_o, pready}, 4'h1);
    apb(1'b0, SCI_CTRL_OFS, 32'h0);
    check(rd, SCI_CTRL_RST);
    apb(1'b0, SCI_MASK_OFS, 32'h0);
    check(rd[5:0], SCI_MASK_RST);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check({err, rd[30:0]}, {1'b1, 31'h0});
    cmd_n <= 1'b0;
    cyc(20);
    check(sup, 1'b0);
    cmd_n <= 1'b1;
    card_presence <= 1'b1;
    cyc(10);
    apb(1'b0, SCI_IRQ_OFS, 32'h0);
    check(rd[SCI_EV_CARD_PRESENCE], 1'b1);
    apb(1'b1, SCI_IRQ_OFS, 32'h3f);
    apb(1'b0, SCI_IRQ_OFS, 32'h0);
    check({rd[5:0], int_oe}, 7'h00);
    $display("test reset and insert done");
    // Software command path: the control register stands in for the pin.
    apb(1'b1, SCI_CTRL_OFS, 32'h3);
    for (t = 0; t < 50 && sup !== 1'b1; t++) cyc(1);
    check(sup, 1'b1);
    cyc(STEP * 2);
    apb(1'b0, SCI_STAT_OFS, 32'h0);
    check(rd[11:0], {2'h0, SCI_ON, 4'h1});
    apb(1'b1, SCI_CTRL_OFS, 32'h1);
    for (t = 0; t < 50 && sup === 1'b1; t++) cyc(1);
    check({sup, crst, cclk}, 3'b000);
    apb(1'b1, SCI_CTRL_OFS, 32'h0);
    apb(1'b1, SCI_IRQ_OFS, 32'h3f);
    $display("test software command done");
    // Each pass activates, then breaks it by one fault or by removal.
    for (k = 0; k < 4; k++)
    begin
      cmd_n <= 1'b1;
      flt <= 4'h0;
      cyc(6);
      vsel <= k[0];
      cyc(6);
      cmd_n <= 1'b0;
      rreq <= 1'b1;
      for (t = 0; t < 50 && sup !== 1'b1; t++) cyc(1);
      check(sup, 1'b1);
      check(v5, k[0]);
      cyc(STEP * 2 + 10);
      check(crst, 1'b1);
      if (k == 0)
      begin
        rreq <= 1'b0;
        cyc(8);
        check(crst, 1'b0);
        rreq <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
          {dh, dl} <= codes[i];
          cyc(120);
          check(per, 6 * divs[i]);
        end
        cpull <= 1'b1;
        cyc(10);
        check({h_oe, hline, c_oe}, 3'b100);
        hpull <= 1'b1;
        cyc(10);
        check(c_oe, 1'b0);
        hpull <= 1'b0;
        cpull <= 1'b0;
        cyc(10);
        check(h_oe, 1'b0);
        hpull <= 1'b1;
        cyc(10);
        check({c_oe, cline, h_oe}, 3'b100);
        hpull <= 1'b0;
        cyc(10);
        check(c_oe, 1'b0);
      end
      flt[k] <= 1'b1;
      t_rst = 0;
      t_do = 0;
      for (t = 1; t < 100 && sup === 1'b1; t++)
      begin
        cyc(1);
        if (t_rst == 0 && crst === 1'b0) t_rst = t;
        if (t_do == 0 && c_oe === 1'b1) t_do = t;
      end
      check(sup, 1'b0);
      check(t_rst > 0 && t_rst < t_do, 1'b1);
      check(cclk, 1'b0);
      apb(1'b0, SCI_IRQ_OFS, 32'h0);
      check(rd[(k < 3) ? SCI_EV_OVC + k : SCI_EV_REMOVE], 1'b1);
      check(rd[SCI_EV_DEACT], 1'b1);
      if (k == 0)
      begin
        apb(1'b1, SCI_MASK_OFS, 32'h0);
        cyc(2);
        check(int_oe, 1'b0);
        apb(1'b1, SCI_MASK_OFS, 32'h3f);
        cyc(2);
        check(int_oe, 1'b1);
        apb(1'b1, SCI_MASK_OFS, 32'h0);
      end
      apb(1'b1, SCI_IRQ_OFS, 32'h3f);
      $display("test fault %0d done", k);
    end
    finish_test();
  end
endmodule : tb_top
